// [ued_pkg.sv]
package ued_pkg;

  // Widths and counts shared by the datapath and the break detector
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int BREAK_BITS = 10;
  localparam int BREAK_CNT_W = 4;

  // Reset values of the control state
  localparam logic SOFT_RESET_N_RST = 1'b0;
  localparam logic PIN_IDLE_LEVEL = 1'b1;

  // Field positions inside the receiver status word
  localparam int ST_PARITY_POS = 0;
  localparam int ST_FRAMING_POS = 1;
  localparam int ST_OVERRUN_POS = 2;
  localparam int ST_WAKE_POS = 3;
  localparam int ST_BREAK_POS = 4;
  localparam int ST_W = 5;

  // Receiver status flags, sticky until cleared
  typedef struct packed {
    logic break_detect_flag;
    logic rx_line_wake_flag;
    logic overrun_flag;
    logic framing_error_flag;
    logic parity_error_flag;
  } ued_rx_status_type;

  // Configuration bits, sampled live, so set them up while the soft reset is held
  typedef struct packed {
    logic rx_enable;
    logic tx_enable;
    logic sleep;
    logic rx_dma_all;
    logic rx_dma_enable;
    logic rx_request_enable;
    logic tx_dma_enable;
    logic tx_request_enable;
    logic rx_error_irq_enable;
    logic break_irq_enable;
    logic line_wake_irq_enable;
    logic clock_internal;
    logic loopback;
    logic rx_pin_function_select;
    logic tx_pin_function_select;
  } ued_cfg_type;

  // One received frame handed over by the frame assembler
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic is_address;
    logic parity_fail;
    logic stop_missing;
  } ued_rx_frame_type;

  // Break detector states
  typedef enum logic [1:0] {
    BRK_IDLE = 2'b00,
    BRK_COUNT = 2'b01,
    BRK_HELD = 2'b10
  } ued_brk_state_type;

endpackage

// [ued_core.sv]
// Contract
// - Set parity, framing, break flags on detection
// - Overrun when unread buffer gets overwritten
// - Overrun with parity sets overrun only
// - Wake flag on power-down block or exit
// - Error summary is OR of five flags
// - Error enable gates parity, framing, overrun
// - Break enable gates break onto error interrupt
// - Break: ten low bits after missed stop
// - Wake enable gates wake onto error interrupt
// - Separate receive and transmit DMA request lines
// - Buffer-free on move; empty when both empty
// - Transmit DMA request on each buffer move
// - Receive DMA request with receive-ready set
// - Error interrupt holds back receive DMA request
// - DMA-all routes address and data frames
// - Otherwise address frames raise receive interrupt
// - Sleep suppresses data-frame DMA requests
// - Soft reset bit resets low, holds module
// - Clock select picks internal or external clock
// - Loopback routes transmitter into receiver
// - Pins serial only when function selected
// - Both DMA bits clear: receive interrupt used
// - Transmit interrupt only with transmit DMA off
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Small flop FIFO in front of the transmit buffer
module ued_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_idx_r;
  logic [AW-1:0] rd_idx_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  if (DEPTH < 2)
  begin : g_bad_depth
    $error("ued_fifo needs at least two entries");
  end

  // Honest flags straight from the occupancy count
  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem_r[rd_idx_r];

  // Storage, written only on an accepted push
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_r[wr_idx_r] <= in_data;
    end
  end

  // Pointers wrap at DEPTH, so any depth of two or more works
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_idx_r <= '0;
      rd_idx_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_idx_r <= (wr_idx_r == AW'(DEPTH - 1)) ? '0 : wr_idx_r + 1'b1;
      end
      if (pop)
      begin
        rd_idx_r <= (rd_idx_r == AW'(DEPTH - 1)) ? '0 : rd_idx_r + 1'b1;
      end
      if (push && !pop)
      begin
        count_r <= count_r + 1'b1;
      end
      else if (pop && !push)
      begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Error flags, error interrupt and DMA request logic of the serial port
module ued_core #(
  parameter int DATA_WIDTH = ued_pkg::DATA_W,
  parameter int FIFO_DEPTH = ued_pkg::FIFO_DEPTH,
  parameter int BREAK_BITS = ued_pkg::BREAK_BITS
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic SOFT_RESET_WR,
  input wire logic SOFT_RESET_N_VALUE,
  output logic SOFT_RESET_N,
  input wire ued_pkg::ued_cfg_type CFG,
  input wire logic INT_BAUD_TICK,
  input wire logic SCLK_PIN,
  output logic BIT_TICK,
  input wire logic RXD_PIN,
  output logic RX_LINE,
  output logic RX_GPIO_IN,
  input wire logic TX_SERIAL_LINE,
  input wire logic TX_GPIO_OUT,
  input wire logic TX_GPIO_OE,
  output logic TXD_PIN_O,
  output logic TXD_PIN_OE,
  input wire logic RX_FRAME_VALID,
  input wire ued_pkg::ued_rx_frame_type RX_FRAME,
  input wire logic RX_BUF_READ,
  output logic [DATA_WIDTH-1:0] RX_BUF_DATA,
  output logic RX_BUF_IS_ADDRESS,
  output logic RX_DATA_AVAILABLE,
  input wire logic PD_ENTRY_BLOCKED,
  input wire logic PD_EXIT_BY_LINE,
  input wire ued_pkg::ued_rx_status_type STATUS_CLEAR,
  output ued_pkg::ued_rx_status_type RX_STATUS,
  output logic RX_ERROR_SUMMARY,
  output logic ERR_IRQ,
  output logic RX_IRQ,
  output logic TX_IRQ,
  output logic RX_DMA_REQ,
  output logic TX_DMA_REQ,
  input wire logic TX_WR_VALID,
  output logic TX_WR_READY,
  input wire logic [DATA_WIDTH-1:0] TX_WR_DATA,
  output logic TX_BUFFER_FREE,
  output logic TX_EMPTY,
  output logic TX_SHIFT_LOAD,
  output logic [DATA_WIDTH-1:0] TX_SHIFT_DATA,
  input wire logic TX_SHIFT_DONE
);

  if (DATA_WIDTH != ued_pkg::DATA_W || BREAK_BITS < 2 ||
      BREAK_BITS >= (1 << ued_pkg::BREAK_CNT_W))
  begin : g_bad_params
    $error("ued_core parameters out of range");
  end

  logic soft_reset_n_r;
  logic mod_rst;
  logic rxd_meta_r;
  logic rxd_sync_r;
  logic sclk_meta_r;
  logic sclk_sync_r;
  logic sclk_prev_r;
  logic rx_line;
  logic txd_r;
  logic txd_oe_r;
  logic rx_move;
  logic overrun_now;
  logic rx_to_dma;
  logic rx_to_irq;
  logic [DATA_WIDTH-1:0] rx_data_r;
  logic rx_addr_r;
  logic rx_ready_r;
  logic rx_dma_pend_r;
  logic rx_irq_pend_r;
  ued_pkg::ued_rx_status_type status_r;
  ued_pkg::ued_rx_status_type status_set;
  ued_pkg::ued_brk_state_type brk_state_r;
  logic [ued_pkg::BREAK_CNT_W-1:0] brk_cnt_r;
  logic brk_found;
  logic fifo_valid;
  logic [DATA_WIDTH-1:0] fifo_data;
  logic tx_buf_full_r;
  logic [DATA_WIDTH-1:0] tx_buf_r;
  logic tx_shift_busy_r;
  logic tx_move;
  logic tx_dma_pend_r;
  logic tx_shift_load_r;
  logic [DATA_WIDTH-1:0] tx_shift_data_r;

  //////////////////////////////////////////////////////////////////////////////
  // Soft reset bit: low after system reset, module held until written high
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      soft_reset_n_r <= ued_pkg::SOFT_RESET_N_RST;
    end
    else if (SOFT_RESET_WR)
    begin
      soft_reset_n_r <= SOFT_RESET_N_VALUE;
    end
  end

  // Config is sampled live, so software must set it up while held here
  assign mod_rst = RST | ~soft_reset_n_r;
  assign SOFT_RESET_N = soft_reset_n_r;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; third clock flop only feeds the edge detector
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      rxd_meta_r <= ued_pkg::PIN_IDLE_LEVEL;
      rxd_sync_r <= ued_pkg::PIN_IDLE_LEVEL;
      sclk_meta_r <= 1'b0;
      sclk_sync_r <= 1'b0;
      sclk_prev_r <= 1'b0;
    end
    else
    begin
      rxd_meta_r <= RXD_PIN;
      rxd_sync_r <= rxd_meta_r;
      sclk_meta_r <= SCLK_PIN;
      sclk_sync_r <= sclk_meta_r;
      sclk_prev_r <= sclk_sync_r;
    end
  end

  // Bit rate from the divider or from rising edges of the clock pin
  assign BIT_TICK = CFG.clock_internal ? INT_BAUD_TICK
                                       : (sclk_sync_r & ~sclk_prev_r);

  // Receive line: internal loop, the pin, or idle when pin is GPIO
  assign rx_line = CFG.loopback ? TX_SERIAL_LINE
                 : (CFG.rx_pin_function_select ? rxd_sync_r
                                               : ued_pkg::PIN_IDLE_LEVEL);
  assign RX_LINE = rx_line;
  assign RX_GPIO_IN = rxd_sync_r;

  // Transmit pin; in loopback the pin idles so the bus sees no test traffic
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      txd_r <= ued_pkg::PIN_IDLE_LEVEL;
      txd_oe_r <= 1'b0;
    end
    else if (CFG.tx_pin_function_select && soft_reset_n_r)
    begin
      txd_r <= CFG.loopback ? ued_pkg::PIN_IDLE_LEVEL : TX_SERIAL_LINE;
      txd_oe_r <= 1'b1;
    end
    else
    begin
      txd_r <= TX_GPIO_OUT;
      txd_oe_r <= TX_GPIO_OE;
    end
  end

  assign TXD_PIN_O = txd_r;
  assign TXD_PIN_OE = txd_oe_r;

  //////////////////////////////////////////////////////////////////////////////
  // Shift-to-buffer transfer; sleep passes address frames only
  assign rx_move = RX_FRAME_VALID & CFG.rx_enable
                 & (~CFG.sleep | RX_FRAME.is_address);

  // A read in the same cycle counts as having taken the old data
  assign overrun_now = rx_move & rx_ready_r & ~RX_BUF_READ;

  // Routing of the ready event: DMA or receive interrupt
  assign rx_to_dma = CFG.rx_request_enable & CFG.rx_dma_enable
                   & (CFG.rx_dma_all | ~RX_FRAME.is_address);
  assign rx_to_irq = CFG.rx_request_enable & ~rx_to_dma;

  // Receive buffer and its ready flag; a new frame beats a read
  always_ff @(posedge CLK)
  begin
    if (mod_rst)
    begin
      rx_data_r <= '0;
      rx_addr_r <= 1'b0;
      rx_ready_r <= 1'b0;
    end
    else if (rx_move)
    begin
      rx_data_r <= RX_FRAME.data;
      rx_addr_r <= RX_FRAME.is_address;
      rx_ready_r <= 1'b1;
    end
    else if (RX_BUF_READ)
    begin
      rx_ready_r <= 1'b0;
    end
  end

  assign RX_BUF_DATA = rx_data_r;
  assign RX_BUF_IS_ADDRESS = rx_addr_r;
  assign RX_DATA_AVAILABLE = rx_ready_r;

  // Pending requests, dropped by any buffer read (DMA or error handler)
  always_ff @(posedge CLK)
  begin
    if (mod_rst)
    begin
      rx_dma_pend_r <= 1'b0;
      rx_irq_pend_r <= 1'b0;
    end
    else
    begin
      rx_dma_pend_r <= (rx_move & rx_to_dma) | (rx_dma_pend_r & ~RX_BUF_READ);
      rx_irq_pend_r <= (rx_move & rx_to_irq) | (rx_irq_pend_r & ~RX_BUF_READ);
    end
  end

  // DMA waits while the error interrupt is up, so errors are seen first
  assign RX_DMA_REQ = rx_dma_pend_r & ~ERR_IRQ;
  assign RX_IRQ = rx_irq_pend_r;

  //////////////////////////////////////////////////////////////////////////////
  // Break detector: counts low bit times after a missed stop bit
  always_ff @(posedge CLK)
  begin
    if (mod_rst)
    begin
      brk_state_r <= ued_pkg::BRK_IDLE;
      brk_cnt_r <= '0;
    end
    else
    begin
      case (brk_state_r)
        ued_pkg::BRK_IDLE:
        begin
          brk_cnt_r <= '0;
          if (RX_FRAME_VALID && RX_FRAME.stop_missing && !rx_line)
          begin
            brk_state_r <= ued_pkg::BRK_COUNT;
          end
        end
        ued_pkg::BRK_COUNT:
        begin
          if (rx_line)
          begin
            brk_state_r <= ued_pkg::BRK_IDLE;
          end
          else if (BIT_TICK)
          begin
            brk_cnt_r <= brk_cnt_r + 1'b1;
            if (brk_cnt_r == ued_pkg::BREAK_CNT_W'(BREAK_BITS - 1))
            begin
              brk_state_r <= ued_pkg::BRK_HELD;
            end
          end
        end
        ued_pkg::BRK_HELD:
        begin
          // Wait for the line to rise so one break reports once
          if (rx_line)
          begin
            brk_state_r <= ued_pkg::BRK_IDLE;
          end
        end
        default:
        begin
          brk_state_r <= ued_pkg::BRK_IDLE;
        end
      endcase
    end
  end

  assign brk_found = (brk_state_r == ued_pkg::BRK_COUNT) & ~rx_line & BIT_TICK
                   & (brk_cnt_r == ued_pkg::BREAK_CNT_W'(BREAK_BITS - 1));

  //////////////////////////////////////////////////////////////////////////////
  // Status flag set terms; flags keep updating during sleep
  always_comb
  begin
    status_set = '0;
    status_set.parity_error_flag = RX_FRAME_VALID & RX_FRAME.parity_fail
                                 & ~overrun_now;
    status_set.framing_error_flag = RX_FRAME_VALID & RX_FRAME.stop_missing;
    status_set.overrun_flag = overrun_now;
    status_set.rx_line_wake_flag = PD_ENTRY_BLOCKED | PD_EXIT_BY_LINE;
    status_set.break_detect_flag = brk_found;
  end

  // Sticky flags, write-one-to-clear, a coinciding set wins
  always_ff @(posedge CLK)
  begin
    if (mod_rst)
    begin
      status_r <= '0;
    end
    else
    begin
      status_r <= (status_r & ~STATUS_CLEAR) | status_set;
    end
  end

  assign RX_STATUS = status_r;
  assign RX_ERROR_SUMMARY = |status_r;

  // Level interrupt; drops as soon as flags or enables go away
  assign ERR_IRQ = (CFG.rx_error_irq_enable & (status_r.parity_error_flag
                     | status_r.framing_error_flag | status_r.overrun_flag))
                 | (CFG.break_irq_enable & status_r.break_detect_flag)
                 | (CFG.line_wake_irq_enable & status_r.rx_line_wake_flag);

  //////////////////////////////////////////////////////////////////////////////
  // Write FIFO stalls the writer when the transmit buffer backs up
  ued_fifo #(
    .WIDTH(DATA_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(CLK),
    .rst(mod_rst),
    .in_valid(TX_WR_VALID),
    .in_ready(TX_WR_READY),
    .in_data(TX_WR_DATA),
    .out_valid(fifo_valid),
    .out_ready(~tx_buf_full_r),
    .out_data(fifo_data)
  );

  // Buffer-to-shift move only while the transmitter is enabled
  assign tx_move = tx_buf_full_r & ~tx_shift_busy_r & CFG.tx_enable;

  // Transmit buffer fills from the FIFO, empties into the shifter
  always_ff @(posedge CLK)
  begin
    if (mod_rst)
    begin
      tx_buf_full_r <= 1'b0;
      tx_buf_r <= '0;
    end
    else if (!tx_buf_full_r && fifo_valid)
    begin
      tx_buf_full_r <= 1'b1;
      tx_buf_r <= fifo_data;
    end
    else if (tx_move)
    begin
      tx_buf_full_r <= 1'b0;
    end
  end

  // Shift register occupancy and load strobe to the bit shifter
  always_ff @(posedge CLK)
  begin
    if (mod_rst)
    begin
      tx_shift_busy_r <= 1'b0;
      tx_shift_load_r <= 1'b0;
      tx_shift_data_r <= '0;
    end
    else
    begin
      tx_shift_busy_r <= tx_move | (tx_shift_busy_r & ~TX_SHIFT_DONE);
      tx_shift_load_r <= tx_move;
      if (tx_move)
      begin
        tx_shift_data_r <= tx_buf_r;
      end
    end
  end

  assign TX_SHIFT_LOAD = tx_shift_load_r;
  assign TX_SHIFT_DATA = tx_shift_data_r;
  assign TX_BUFFER_FREE = ~tx_buf_full_r;
  assign TX_EMPTY = ~tx_buf_full_r & ~tx_shift_busy_r;

  // Transmit DMA request per move, held until the next word is accepted
  always_ff @(posedge CLK)
  begin
    if (mod_rst)
    begin
      tx_dma_pend_r <= 1'b0;
    end
    else
    begin
      tx_dma_pend_r <= (tx_move & CFG.tx_dma_enable & CFG.tx_request_enable)
                     | (tx_dma_pend_r & ~(TX_WR_VALID & TX_WR_READY));
    end
  end

  assign TX_DMA_REQ = tx_dma_pend_r;
  // Level request: re-asserts whenever the action enable returns
  assign TX_IRQ = CFG.tx_request_enable & ~CFG.tx_dma_enable & ~tx_buf_full_r;

endmodule

// [ued_chk.sv]
`timescale 1ns/10ps
////////////////////////////////////////
// Watches flags, interrupts and requests at the core's ports
module ued_chk (
  input wire logic CLK,
  input wire logic RST,
  input wire logic SOFT_RESET_N,
  input wire ued_pkg::ued_cfg_type CFG,
  input wire logic INT_BAUD_TICK,
  input wire logic BIT_TICK,
  input wire logic RX_LINE,
  input wire logic TX_SERIAL_LINE,
  input wire logic RX_FRAME_VALID,
  input wire ued_pkg::ued_rx_frame_type RX_FRAME,
  input wire logic RX_BUF_READ,
  input wire logic RX_DATA_AVAILABLE,
  input wire logic PD_ENTRY_BLOCKED,
  input wire logic PD_EXIT_BY_LINE,
  input wire ued_pkg::ued_rx_status_type RX_STATUS,
  input wire logic RX_ERROR_SUMMARY,
  input wire logic ERR_IRQ,
  input wire logic TX_IRQ,
  input wire logic RX_DMA_REQ,
  input wire logic TX_DMA_REQ,
  input wire logic TX_WR_VALID,
  input wire logic TX_BUFFER_FREE,
  input wire logic TX_SHIFT_LOAD
);
  logic take;
  logic err_cause;
  // Frame moving into the buffer this cycle
  assign take = RX_FRAME_VALID & SOFT_RESET_N & CFG.rx_enable
    & (~CFG.sleep | RX_FRAME.is_address);
  // Enabled sources; break does not need the error enable
  assign err_cause = (CFG.rx_error_irq_enable & (RX_STATUS.parity_error_flag
    | RX_STATUS.framing_error_flag | RX_STATUS.overrun_flag))
    | (CFG.break_irq_enable & RX_STATUS.break_detect_flag)
    | (CFG.line_wake_irq_enable & RX_STATUS.rx_line_wake_flag);

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  a_summary_or: assert property (RX_ERROR_SUMMARY == (|RX_STATUS))
    else $error("summary bit wrong");
  a_err_level: assert property (ERR_IRQ == err_cause)
    else $error("error interrupt wrong");
  a_wake_set: assert property (
    SOFT_RESET_N && (PD_EXIT_BY_LINE || PD_ENTRY_BLOCKED) |=> RX_STATUS.rx_line_wake_flag)
    else $error("wake flag not set");
  a_overrun_set: assert property (
    take && RX_DATA_AVAILABLE && !RX_BUF_READ |=> RX_STATUS.overrun_flag)
    else $error("overrun not flagged");
  a_dma_held: assert property (ERR_IRQ |-> !RX_DMA_REQ)
    else $error("receive request beside error");
  a_rx_dma: assert property (
    take && CFG.rx_request_enable && CFG.rx_dma_enable
    && (CFG.rx_dma_all || !RX_FRAME.is_address) |=> RX_DMA_REQ || ERR_IRQ)
    else $error("receive request missing");
  a_sleep_quiet: assert property (
    RX_FRAME_VALID && CFG.sleep && !RX_FRAME.is_address && !RX_DATA_AVAILABLE
    |=> !RX_DATA_AVAILABLE && !RX_DMA_REQ) else $error("data frame taken asleep");
  a_tx_irq: assert property (
    SOFT_RESET_N |-> TX_IRQ == (CFG.tx_request_enable && !CFG.tx_dma_enable
    && TX_BUFFER_FREE)) else $error("transmit interrupt wrong");
  a_tx_dma: assert property (
    TX_SHIFT_LOAD && CFG.tx_dma_enable && CFG.tx_request_enable && !$past(TX_WR_VALID)
    |-> TX_DMA_REQ) else $error("transmit request missing");
  a_soft_hold: assert property (
    (!SOFT_RESET_N) [*2] |-> RX_STATUS == '0 && !RX_DMA_REQ && !TX_DMA_REQ)
    else $error("activity in soft reset");
  a_loop_route: assert property (
    CFG.loopback |-> RX_LINE == TX_SERIAL_LINE) else $error("loopback wrong");
  a_clock_sel: assert property (
    CFG.clock_internal |-> BIT_TICK == INT_BAUD_TICK) else $error("bit tick wrong");
endmodule

// [ued_txs_model.sv]
`timescale 1ns/10ps
////////////////////////////////////////
// Bit shifter behind the transmit buffer; hold stalls it so the
// buffers in front fill as on a slow line
module ued_txs_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [ued_pkg::DATA_W-1:0] data,
  input wire logic hold,
  output logic done,
  output logic [ued_pkg::DATA_W-1:0] last_r,
  output logic [3:0] seen_r
);
  logic busy_r;
  logic [1:0] cnt_r;
  // Four free cycles per word, then one done pulse
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy_r <= 1'b0;
      cnt_r <= 2'h0;
      seen_r <= 4'h0;
      done <= 1'b0;
    end
    else if (load)
    begin
      busy_r <= 1'b1;
      last_r <= data;
      seen_r <= seen_r + 4'h1;
      done <= 1'b0;
    end
    else
    begin
      done <= busy_r && !hold && (cnt_r == 2'h3);
      if (busy_r && !hold)
        cnt_r <= cnt_r + 2'h1;
      if (busy_r && !hold && (cnt_r == 2'h3))
        busy_r <= 1'b0;
    end
  end
endmodule

// [test_uart_error_irq_dma_request.sv]
`timescale 1ns/10ps
module test_uart_error_irq_dma_request;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sr_wr = 1'b0;
  logic sr_val = 1'b0;
  ued_pkg::ued_cfg_type cfg = '0;
  logic tick = 1'b0;
  logic sclk = 1'b0;
  logic txo, txoe, rxg, radr;
  logic tx_line = 1'b1;
  logic fv = 1'b0;
  ued_pkg::ued_rx_frame_type fr = '0;
  logic rd = 1'b0;
  logic pd_blk = 1'b0;
  logic pd_exit = 1'b0;
  ued_pkg::ued_rx_status_type st_clr = '0;
  logic wv = 1'b0;
  logic [7:0] wd = 8'h00;
  logic hold = 1'b1;
  logic srn, avail, summ, err, rx_irq, tx_irq, rdma, tdma;
  logic wr_rdy, tfree, tempty, load, done;
  logic [7:0] rx_data, sdata, last;
  logic [3:0] seen;
  ued_pkg::ued_rx_status_type status;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;

  always #20 clk = ~clk;

  ////////////////////////////////////////
  // Line inputs left at idle; loopback gives the line a low level
  ued_core DUT (
    .CLK(clk), .RST(rst), .SOFT_RESET_WR(sr_wr), .SOFT_RESET_N_VALUE(sr_val),
    .SOFT_RESET_N(srn), .CFG(cfg), .INT_BAUD_TICK(tick), .SCLK_PIN(sclk),
    .BIT_TICK(), .RXD_PIN(1'b1), .RX_LINE(), .RX_GPIO_IN(rxg),
    .TX_SERIAL_LINE(tx_line), .TX_GPIO_OUT(1'b1), .TX_GPIO_OE(1'b0),
    .TXD_PIN_O(txo), .TXD_PIN_OE(txoe), .RX_FRAME_VALID(fv), .RX_FRAME(fr),
    .RX_BUF_READ(rd), .RX_BUF_DATA(rx_data), .RX_BUF_IS_ADDRESS(radr),
    .RX_DATA_AVAILABLE(avail), .PD_ENTRY_BLOCKED(pd_blk), .PD_EXIT_BY_LINE(pd_exit),
    .STATUS_CLEAR(st_clr), .RX_STATUS(status), .RX_ERROR_SUMMARY(summ),
    .ERR_IRQ(err), .RX_IRQ(rx_irq), .TX_IRQ(tx_irq), .RX_DMA_REQ(rdma),
    .TX_DMA_REQ(tdma), .TX_WR_VALID(wv), .TX_WR_READY(wr_rdy), .TX_WR_DATA(wd),
    .TX_BUFFER_FREE(tfree), .TX_EMPTY(tempty), .TX_SHIFT_LOAD(load),
    .TX_SHIFT_DATA(sdata), .TX_SHIFT_DONE(done)
  );
  ued_txs_model SHF (.clk(clk), .rst(rst), .load(load), .data(sdata), .hold(hold),
    .done(done), .last_r(last), .seen_r(seen));

  ////////////////////////////////////////
  task automatic chk(input logic [15:0] seen_v, input logic [15:0] exp_v);
    compares++;
    if (seen_v !== exp_v)
    begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Flag field is address, parity fail, stop missing; gap keeps pulses apart
  task frame(input logic [7:0] d, input logic [2:0] f);
    fr = {d, f};
    fv = 1'b1;
    cyc(1);
    fv = 1'b0;
    cyc(1);
  endtask
  // Divider tick and clock pin together; tail covers the pin synchroniser
  task ticks(input int n);
    repeat (n)
    begin
      tick = 1'b1;
      sclk = 1'b1;
      cyc(1);
      tick = 1'b0;
      sclk = 1'b0;
      cyc(1);
    end
    cyc(2);
  endtask
  // Read the buffer and clear every flag so tests stay independent
  task flush;
    st_clr = '1;
    rd = 1'b1;
    cyc(1);
    st_clr = '0;
    rd = 1'b0;
    cyc(1);
  endtask
  task conclude;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task t_soft;
    chk({srn, tfree, tempty, txoe, rxg}, 5'b01101);
    pd_exit = 1'b1;
    cyc(1);
    pd_exit = 1'b0;
    cyc(1);
    chk(status, 5'h00);
    cfg = 15'h678B;
    sr_val = 1'b1;
    sr_wr = 1'b1;
    cyc(1);
    sr_wr = 1'b0;
    chk(srn, 1'b1);
    $display("test soft done");
  endtask
  task t_wake;
    cfg.line_wake_irq_enable = 1'b1;
    pd_exit = 1'b1;
    cyc(1);
    pd_exit = 1'b0;
    chk({status, summ, err}, 7'b01000_11);
    cfg.line_wake_irq_enable = 1'b0;
    #1;
    chk(err, 1'b0);
    flush;
    pd_blk = 1'b1;
    cyc(1);
    pd_blk = 1'b0;
    chk(status, 5'h08);
    flush;
    $display("test wake done");
  endtask
  task t_route;
    for (int a = 0; a < 2; a++)
    begin
      cfg.rx_dma_all = a[0];
      frame(8'h55, 3'b000);
      chk({avail, rdma, rx_irq, tdma, rx_data}, {4'b1100, 8'h55});
      flush;
      chk({avail, rdma}, 2'b00);
      frame(8'hA5, 3'b100);
      chk({rdma, rx_irq, radr}, {a[0], !a[0], 1'b1});
      flush;
    end
    cfg.rx_dma_all = 1'b0;
    cfg.rx_dma_enable = 1'b0;
    frame(8'h5A, 3'b000);
    chk({rdma, rx_irq}, 2'b01);
    flush;
    cfg.rx_dma_enable = 1'b1;
    $display("test route done");
  endtask
  task t_err;
    cfg.rx_error_irq_enable = 1'b1;
    frame(8'h11, 3'b000);
    chk(rdma, 1'b1);
    frame(8'h22, 3'b010);
    chk({status, err, rdma, rx_data}, {7'b00100_10, 8'h22});
    flush;
    chk({err, rdma, avail}, 3'b000);
    frame(8'h33, 3'b010);
    chk({status, err}, 6'b00001_1);
    flush;
    frame(8'h44, 3'b001);
    chk({status, err}, 6'b00010_1);
    flush;
    cfg.rx_error_irq_enable = 1'b0;
    $display("test errors done");
  endtask
  task t_sleep;
    cfg.sleep = 1'b1;
    frame(8'h66, 3'b000);
    chk({avail, rdma}, 2'b00);
    frame(8'h07, 3'b100);
    chk({avail, rx_irq, rx_data}, {2'b11, 8'h07});
    flush;
    cfg.sleep = 1'b0;
    $display("test sleep done");
  endtask
  // Looped line held low after a missed stop bit, clock pin then divider
  task t_brk;
    cfg.loopback = 1'b1;
    cfg.break_irq_enable = 1'b1;
    for (int c = 0; c < 2; c++)
    begin
      cfg.clock_internal = c[0];
      tx_line = 1'b0;
      frame(8'h00, 3'b001);
      ticks(9);
      chk(status.break_detect_flag, 1'b0);
      ticks(1);
      chk({status.break_detect_flag, err, txo, txoe}, 4'b1111);
      tx_line = 1'b1;
      flush;
    end
    cfg.loopback = 1'b0;
    cfg.break_irq_enable = 1'b0;
    $display("test break done");
  endtask
  // Fill with the shifter stalled until refused, then drain
  task t_tx;
    int n;
    logic acc;
    n = 0;
    wv = 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      wd = 8'hA0 + n[7:0];
      acc = wr_rdy;
      cyc(1);
      if (acc === 1'b1)
        n++;
    end
    wv = 1'b0;
    chk(n[15:0], 16'(ued_pkg::FIFO_DEPTH + 2));
    chk({tfree, tempty, tdma}, 3'b000);
    hold = 1'b0;
    for (int i = 0; i < 200 && tempty !== 1'b1; i++)
      cyc(1);
    chk({tempty, tfree, tdma, seen}, {3'b111, 4'h6});
    chk(last, 8'hA5);
    $display("test transmit done");
  endtask

  // Cuts a hung run short
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      conclude;
    end
  end

  initial
  begin
    cyc(13);
    rst = 1'b0;
    t_soft;
    t_wake;
    t_route;
    t_err;
    t_sleep;
    t_brk;
    t_tx;
    conclude;
  end
endmodule

bind ued_core ued_chk CHK (
  .CLK(CLK), .RST(RST), .SOFT_RESET_N(SOFT_RESET_N), .CFG(CFG),
  .INT_BAUD_TICK(INT_BAUD_TICK), .BIT_TICK(BIT_TICK), .RX_LINE(RX_LINE),
  .TX_SERIAL_LINE(TX_SERIAL_LINE), .RX_FRAME_VALID(RX_FRAME_VALID),
  .RX_FRAME(RX_FRAME), .RX_BUF_READ(RX_BUF_READ), .RX_DATA_AVAILABLE(RX_DATA_AVAILABLE),
  .PD_ENTRY_BLOCKED(PD_ENTRY_BLOCKED), .PD_EXIT_BY_LINE(PD_EXIT_BY_LINE),
  .RX_STATUS(RX_STATUS), .RX_ERROR_SUMMARY(RX_ERROR_SUMMARY), .ERR_IRQ(ERR_IRQ),
  .TX_IRQ(TX_IRQ), .RX_DMA_REQ(RX_DMA_REQ), .TX_DMA_REQ(TX_DMA_REQ),
  .TX_WR_VALID(TX_WR_VALID), .TX_BUFFER_FREE(TX_BUFFER_FREE),
  .TX_SHIFT_LOAD(TX_SHIFT_LOAD)
);
